// *** src/periph_exec_regs.vh ***
/*
  constants of the peripheral instruction executor: register
  offsets, field positions, reset values and instruction codes.
  assumes: included by periph_exec.v and the tb files, definitions only.
*/
`ifndef PERIPH_EXEC_REGS_VH
`define PERIPH_EXEC_REGS_VH
// Functional notes
// [RQ1] port reads copy P0/P1 into A; P2/P3 use only A1..A0
// [RQ2] set all port D, or clear/set the D bit chosen by Y 0..5
// [RQ3] two-word D bit test skips when the chosen D bit reads 0
// [RQ4] port C set drives 1, clear drives 0, test skips on 1
// [RQ5] port K read puts level in A0, clears A3..A1; write drives A0
// [RQ6] three key wakeup registers load from A and read back into A
// [RQ7] three pull-up registers load from A, never read back
// [RQ8] converter control loads and reads A; bit 3 picks the mode
// [RQ9] converter start clears done flag, starts conversion or compare
// [RQ10] conversion mode result read: bits 9..6 to B, 5..2 to A
// [RQ11] comparator mode result read: bits 7..4 to B, 3..0 to A
// [RQ12] low result read: bits 1..0 to A3..A2, A1..A0 cleared
// [RQ13] comparator load is a no-op in conversion mode, else B:A
// [RQ14] done test with irq bit 2 low skips on flag, then clears it
// [RQ15] only the word right after the arm makes power-down effective
// [RQ16] first armed power-down keeps the voltage detector running
// [RQ17] second armed power-down stops all, the detector too
// [RQ18] power flag test skips on 1 and leaves the flag alone
// [RQ19] watchdog flag test skips on flag 1, then clears it
// [RQ20] watchdog flag test right after stop-arm stops the watchdog
// [RQ21] clock selects pick ceramic or RC, both stop on-chip osc
// [RQ22] clock control register loads from and reads into A
// [RQ23] words are 10 bits: bits 9..4 high code, 3..0 low code
// [RQ24] second word of the D bit test must be 00 0010 1011
// ===========================================================
// register offsets
`define OFS_INSTR   8'h00
`define OFS_ACC     8'h04
`define OFS_BREG    8'h08
`define OFS_YREG    8'h0C
`define OFS_IRQCTL2 8'h10
`define OFS_STATUS  8'h14
// ===========================================================
// fields and reset values
`define MODE_BIT    3
`define CONV_IE_BIT 2
`define RST_NIB     4'hF
`define RST_PAIR    2'h3
`define RST_PORTD   6'h3F
`define RST_CTL     4'h0
// ===========================================================
// instruction codes
`define OP_IN_P0    10'h260
`define OP_OUT_P0   10'h220
`define OP_IN_P1    10'h261
`define OP_OUT_P1   10'h221
`define OP_IN_P2    10'h262
`define OP_OUT_P2   10'h222
`define OP_IN_P3    10'h263
`define OP_OUT_P3   10'h223
`define OP_D_ALL    10'h011
`define OP_D_CLR    10'h014
`define OP_D_SET    10'h015
`define OP_D_TEST   10'h024
`define OP_D_TEST2  10'h02B
`define OP_C_SET    10'h28D
`define OP_C_CLR    10'h28C
`define OP_C_TEST   10'h289
`define OP_K_RD     10'h26F
`define OP_K_WR     10'h21F
`define OP_KW0_LD   10'h21B
`define OP_KW0_RD   10'h256
`define OP_KW1_LD   10'h214
`define OP_KW1_RD   10'h259
`define OP_KW2_LD   10'h215
`define OP_KW2_RD   10'h25A
`define OP_PU0_LD   10'h22D
`define OP_PU1_LD   10'h22E
`define OP_PU2_LD   10'h22F
`define OP_RES_RD   10'h279
`define OP_LOW_RD   10'h249
`define OP_CMP_LD   10'h239
`define OP_CCTL_RD  10'h244
`define OP_CCTL_LD  10'h204
`define OP_CSTART   10'h29F
`define OP_DONE_T   10'h287
`define OP_PD1      10'h002
`define OP_PD2      10'h008
`define OP_PD_ARM   10'h05B
`define OP_PF_TEST  10'h003
`define OP_WD_ARM   10'h29C
`define OP_WD_TEST  10'h2A0
`define OP_CERAMIC  10'h29A
`define OP_RC       10'h29B
`define OP_MR_RD    10'h252
`define OP_MR_LD    10'h216
`endif

// *** src/periph_exec.v ***
/*
  peripheral instruction executor: runs the port, key wakeup,
  pull-up, converter, power-down, watchdog and clock select
  instructions of a 4-bit core, one word per APB write.
  assumes: pins are open-drain style and asynchronous; flag set
  strobes, power flag and converter result come from pclk logic.
*/
`include "periph_exec_regs.vh"

module periph_exec (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // ports p0..p3
  input  wire [3:0]  p0_in,
  output wire [3:0]  p0_out,
  output wire [3:0]  p0_oe_n,
  input  wire [3:0]  p1_in,
  output wire [3:0]  p1_out,
  output wire [3:0]  p1_oe_n,
  input  wire [1:0]  p2_in,
  output wire [1:0]  p2_out,
  output wire [1:0]  p2_oe_n,
  input  wire [1:0]  p3_in,
  output wire [1:0]  p3_out,
  output wire [1:0]  p3_oe_n,
  // ports d, c, k
  input  wire [5:0]  d_in,
  output wire [5:0]  d_out,
  output wire [5:0]  d_oe_n,
  input  wire        c_in,
  output wire        c_out,
  output wire        c_oe_n,
  input  wire        k_in,
  output wire        k_out,
  output wire        k_oe_n,
  // core side inputs
  input  wire        power_flag,
  input  wire        wdf_set,
  input  wire        conv_done_set,
  input  wire [9:0]  conv_result,
  // control registers
  output reg  [3:0]  key_wake_ctl_0,
  output reg  [3:0]  key_wake_ctl_1,
  output reg  [3:0]  key_wake_ctl_2,
  output reg  [3:0]  pullup_ctl_0,
  output reg  [3:0]  pullup_ctl_1,
  output reg  [3:0]  pullup_ctl_2,
  output reg  [3:0]  conv_ctl_reg,
  output reg  [7:0]  comparator_value,
  output reg  [3:0]  clock_ctl_reg,
  // events and levels
  output reg         skip,
  output reg         conv_start,
  output wire        conv_mode_bit,
  output reg         backup_with_detector,
  output reg         backup_all_stopped,
  output reg         watchdog_stop,
  output reg         clk_src_rc,
  output reg         onchip_osc_off
);

  // ===========================================================
  // state
  reg  [3:0]  acc_q;
  reg  [3:0]  acc_d;
  reg  [3:0]  b_q;
  reg  [3:0]  b_d;
  reg  [3:0]  y_q;
  reg  [3:0]  y_d;
  reg  [3:0]  v2_q;
  reg  [3:0]  v2_d;
  reg  [9:0]  last_q;
  reg  [3:0]  p0_q;
  reg  [3:0]  p0_d;
  reg  [3:0]  p1_q;
  reg  [3:0]  p1_d;
  reg  [1:0]  p2_q;
  reg  [1:0]  p2_d;
  reg  [1:0]  p3_q;
  reg  [1:0]  p3_d;
  reg  [5:0]  d_q;
  reg  [5:0]  d_d;
  reg         c_q;
  reg         c_d;
  reg         k_q;
  reg         k_d;
  reg  [3:0]  kw0_d;
  reg  [3:0]  kw1_d;
  reg  [3:0]  kw2_d;
  reg  [3:0]  pu0_d;
  reg  [3:0]  pu1_d;
  reg  [3:0]  pu2_d;
  reg  [3:0]  q1_d;
  reg  [7:0]  cmp_d;
  reg  [3:0]  mr_d;
  reg         skip_d;
  reg         szd_q;
  reg         szd_d;
  reg         arm_q;
  reg         arm_d;
  reg         wda_q;
  reg         wda_d;
  reg         adf_q;
  reg         adf_d;
  reg         wdf_q;
  reg         wdf_d;
  reg         start_d;
  reg         pd1_d;
  reg         pd2_d;
  reg         wstop_d;
  reg         rc_d;
  reg         ooff_d;
  // pin synchronisers
  reg  [19:0] s1_q;
  reg  [19:0] s2_q;
  reg  [19:0] s3_q;
  reg  [19:0] pin_q;

  wire [19:0] agree;
  wire [5:0]  hi;
  wire [3:0]  lo;
  wire        wr;
  wire        ex;
  wire [5:0]  ymask;

  // ===========================================================
  // helpers
  // one-hot port D bit from Y; no bit for Y above 5
  function [5:0] ybit;
    input [3:0] y;
    begin
      ybit = (y < 4'h6) ? (6'h01 << y[2:0]) : 6'h00;
    end
  endfunction

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFS_INSTR) || (a == `OFS_ACC) ||
               (a == `OFS_BREG) || (a == `OFS_YREG) ||
               (a == `OFS_IRQCTL2) || (a == `OFS_STATUS);
    end
  endfunction

  // ===========================================================
  // pin inputs: a change counts once stages two and three agree
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q  <= 20'hFFFFF;
      s2_q  <= 20'hFFFFF;
      s3_q  <= 20'hFFFFF;
      pin_q <= 20'hFFFFF;
    end
    else
    begin
      s1_q  <= {k_in, c_in, d_in, p3_in, p2_in, p1_in, p0_in};
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      pin_q <= (s3_q & agree) | (pin_q & ~agree);
    end
  end

  assign agree = ~(s2_q ^ s3_q);

  // ===========================================================
  // apb: zero wait states, read data caught in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped(paddr);
  assign wr      = psel & penable & pwrite;
  assign ex      = wr & (paddr == `OFS_INSTR);
  // [RQ23] high and low code fields
  assign hi      = pwdata[9:4];
  assign lo      = pwdata[3:0];
  assign ymask   = ybit(y_q);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
    begin
      if (paddr == `OFS_INSTR)
        prdata <= {22'h00000, last_q};
      else if (paddr == `OFS_ACC)
        prdata <= {28'h0000000, acc_q};
      else if (paddr == `OFS_BREG)
        prdata <= {28'h0000000, b_q};
      else if (paddr == `OFS_YREG)
        prdata <= {28'h0000000, y_q};
      else if (paddr == `OFS_IRQCTL2)
        prdata <= {28'h0000000, v2_q};
      else if (paddr == `OFS_STATUS)
        prdata <= {24'h000000, onchip_osc_off, clk_src_rc, wda_q,
                   arm_q, szd_q, wdf_q, adf_q, skip};
      else
        prdata <= 32'h00000000;
    end
  end

  // ===========================================================
  // instruction execution
  always @*
  begin
    acc_d   = acc_q;
    b_d     = b_q;
    y_d     = y_q;
    v2_d    = v2_q;
    p0_d    = p0_q;
    p1_d    = p1_q;
    p2_d    = p2_q;
    p3_d    = p3_q;
    d_d     = d_q;
    c_d     = c_q;
    k_d     = k_q;
    kw0_d   = key_wake_ctl_0;
    kw1_d   = key_wake_ctl_1;
    kw2_d   = key_wake_ctl_2;
    pu0_d   = pullup_ctl_0;
    pu1_d   = pullup_ctl_1;
    pu2_d   = pullup_ctl_2;
    q1_d    = conv_ctl_reg;
    cmp_d   = comparator_value;
    mr_d    = clock_ctl_reg;
    skip_d  = skip;
    szd_d   = szd_q;
    arm_d   = arm_q;
    wda_d   = wda_q;
    adf_d   = adf_q;
    wdf_d   = wdf_q;
    start_d = 1'b0;
    pd1_d   = 1'b0;
    pd2_d   = 1'b0;
    wstop_d = 1'b0;
    rc_d    = clk_src_rc;
    ooff_d  = onchip_osc_off;
    if (wr & (paddr == `OFS_ACC))
      acc_d = pwdata[3:0];
    else if (wr & (paddr == `OFS_BREG))
      b_d = pwdata[3:0];
    else if (wr & (paddr == `OFS_YREG))
      y_d = pwdata[3:0];
    else if (wr & (paddr == `OFS_IRQCTL2))
      v2_d = pwdata[3:0];
    if (ex)
    begin
      // arms last for exactly one following word
      skip_d = 1'b0;
      arm_d  = 1'b0;
      wda_d  = 1'b0;
      szd_d  = 1'b0;
      if (szd_q)
      begin
        // [RQ24] fixed second word
        if ({hi, lo} == `OP_D_TEST2)
          // [RQ3] skip on zero bit
          skip_d = ~|(pin_q[17:12] & ymask) & |ymask;
      end
      else
      begin
        case ({hi, lo})
          // [RQ1] port transfers
          `OP_IN_P0:   acc_d = pin_q[3:0];
          `OP_IN_P1:   acc_d = pin_q[7:4];
          `OP_IN_P2:   acc_d = {2'b00, pin_q[9:8]};
          `OP_IN_P3:   acc_d = {2'b00, pin_q[11:10]};
          `OP_OUT_P0:  p0_d = acc_q;
          `OP_OUT_P1:  p1_d = acc_q;
          `OP_OUT_P2:  p2_d = acc_q[1:0];
          `OP_OUT_P3:  p3_d = acc_q[1:0];
          // [RQ2] port d bit ops
          `OP_D_ALL:   d_d = `RST_PORTD;
          `OP_D_CLR:   d_d = d_q & ~ymask;
          `OP_D_SET:   d_d = d_q | ymask;
          // [RQ3] first word of test
          `OP_D_TEST:  szd_d = 1'b1;
          // [RQ4] port c ops
          `OP_C_SET:   c_d = 1'b1;
          `OP_C_CLR:   c_d = 1'b0;
          `OP_C_TEST:  skip_d = pin_q[18];
          // [RQ5] port k ops
          `OP_K_RD:    acc_d = {3'b000, pin_q[19]};
          `OP_K_WR:    k_d = acc_q[0];
          // [RQ6] key wakeup transfers
          `OP_KW0_LD:  kw0_d = acc_q;
          `OP_KW0_RD:  acc_d = key_wake_ctl_0;
          `OP_KW1_LD:  kw1_d = acc_q;
          `OP_KW1_RD:  acc_d = key_wake_ctl_1;
          `OP_KW2_LD:  kw2_d = acc_q;
          `OP_KW2_RD:  acc_d = key_wake_ctl_2;
          // [RQ7] pull-up loads
          `OP_PU0_LD:  pu0_d = acc_q;
          `OP_PU1_LD:  pu1_d = acc_q;
          `OP_PU2_LD:  pu2_d = acc_q;
          // [RQ8] converter control
          `OP_CCTL_LD: q1_d = acc_q;
          `OP_CCTL_RD: acc_d = conv_ctl_reg;
          `OP_RES_RD:
          begin
            // [RQ11] comparator mode read
            if (conv_ctl_reg[`MODE_BIT])
            begin
              b_d   = comparator_value[7:4];
              acc_d = comparator_value[3:0];
            end
            else
            begin
              // [RQ10] conversion mode read
              b_d   = conv_result[9:6];
              acc_d = conv_result[5:2];
            end
          end
          // [RQ12] low result bits
          `OP_LOW_RD:  acc_d = {conv_result[1:0], 2'b00};
          `OP_CMP_LD:
          begin
            // [RQ13] no-op in conversion mode
            if (conv_ctl_reg[`MODE_BIT])
              cmp_d = {b_q, acc_q};
          end
          `OP_CSTART:
          begin
            // [RQ9] clear flag and start
            adf_d   = 1'b0;
            start_d = 1'b1;
          end
          `OP_DONE_T:
          begin
            // [RQ14] test only while irq bit low
            if (~v2_q[`CONV_IE_BIT] & adf_q)
            begin
              skip_d = 1'b1;
              adf_d  = 1'b0;
            end
          end
          // [RQ15] arm for the next word only
          `OP_PD_ARM:  arm_d = 1'b1;
          // [RQ16] detector kept running
          `OP_PD1:     pd1_d = arm_q;
          // [RQ17] all functions stopped
          `OP_PD2:     pd2_d = arm_q;
          // [RQ18] flag left unchanged
          `OP_PF_TEST: skip_d = power_flag;
          `OP_WD_ARM:  wda_d = 1'b1;
          `OP_WD_TEST:
          begin
            // [RQ19] skip and clear
            if (wdf_q)
            begin
              skip_d = 1'b1;
              wdf_d  = 1'b0;
            end
            // [RQ20] stop after stop-arm
            wstop_d = wda_q;
          end
          `OP_CERAMIC:
          begin
            // [RQ21] ceramic select
            rc_d   = 1'b0;
            ooff_d = 1'b1;
          end
          `OP_RC:
          begin
            // [RQ21] rc select
            rc_d   = 1'b1;
            ooff_d = 1'b1;
          end
          // [RQ22] clock control transfers
          `OP_MR_LD:   mr_d = acc_q;
          `OP_MR_RD:   acc_d = clock_ctl_reg;
          default:     skip_d = 1'b0;
        endcase
      end
    end
    // a flag set in the clearing cycle is not lost
    if (conv_done_set)
      adf_d = 1'b1;
    if (wdf_set)
      wdf_d = 1'b1;
  end

  // ===========================================================
  // registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q                <= `RST_CTL;
      b_q                  <= `RST_CTL;
      y_q                  <= `RST_CTL;
      v2_q                 <= `RST_CTL;
      last_q               <= 10'h000;
      p0_q                 <= `RST_NIB;
      p1_q                 <= `RST_NIB;
      p2_q                 <= `RST_PAIR;
      p3_q                 <= `RST_PAIR;
      d_q                  <= `RST_PORTD;
      c_q                  <= 1'b1;
      k_q                  <= 1'b1;
      key_wake_ctl_0       <= `RST_CTL;
      key_wake_ctl_1       <= `RST_CTL;
      key_wake_ctl_2       <= `RST_CTL;
      pullup_ctl_0         <= `RST_CTL;
      pullup_ctl_1         <= `RST_CTL;
      pullup_ctl_2         <= `RST_CTL;
      conv_ctl_reg         <= `RST_CTL;
      comparator_value     <= 8'h00;
      clock_ctl_reg        <= `RST_CTL;
      skip                 <= 1'b0;
      szd_q                <= 1'b0;
      arm_q                <= 1'b0;
      wda_q                <= 1'b0;
      adf_q                <= 1'b0;
      wdf_q                <= 1'b0;
      conv_start           <= 1'b0;
      backup_with_detector <= 1'b0;
      backup_all_stopped   <= 1'b0;
      watchdog_stop        <= 1'b0;
      clk_src_rc           <= 1'b0;
      onchip_osc_off       <= 1'b0;
    end
    else
    begin
      acc_q                <= acc_d;
      b_q                  <= b_d;
      y_q                  <= y_d;
      v2_q                 <= v2_d;
      if (ex)
        last_q             <= pwdata[9:0];
      p0_q                 <= p0_d;
      p1_q                 <= p1_d;
      p2_q                 <= p2_d;
      p3_q                 <= p3_d;
      d_q                  <= d_d;
      c_q                  <= c_d;
      k_q                  <= k_d;
      key_wake_ctl_0       <= kw0_d;
      key_wake_ctl_1       <= kw1_d;
      key_wake_ctl_2       <= kw2_d;
      pullup_ctl_0         <= pu0_d;
      pullup_ctl_1         <= pu1_d;
      pullup_ctl_2         <= pu2_d;
      conv_ctl_reg         <= q1_d;
      comparator_value     <= cmp_d;
      clock_ctl_reg        <= mr_d;
      skip                 <= skip_d;
      szd_q                <= szd_d;
      arm_q                <= arm_d;
      wda_q                <= wda_d;
      adf_q                <= adf_d;
      wdf_q                <= wdf_d;
      conv_start           <= start_d;
      backup_with_detector <= pd1_d;
      backup_all_stopped   <= pd2_d;
      watchdog_stop        <= wstop_d;
      clk_src_rc           <= rc_d;
      onchip_osc_off       <= ooff_d;
    end
  end

  // ===========================================================
  // pins: open drain, a latch of 0 pulls the pin low
  assign p0_out        = p0_q;
  assign p0_oe_n       = p0_q;
  assign p1_out        = p1_q;
  assign p1_oe_n       = p1_q;
  assign p2_out        = p2_q;
  assign p2_oe_n       = p2_q;
  assign p3_out        = p3_q;
  assign p3_oe_n       = p3_q;
  assign d_out         = d_q;
  assign d_oe_n        = d_q;
  assign c_out         = c_q;
  assign c_oe_n        = c_q;
  assign k_out         = k_q;
  assign k_oe_n        = k_q;
  assign conv_mode_bit = conv_ctl_reg[`MODE_BIT];

endmodule // periph_exec

// *** tb/periph_exec_properties.sv ***
/*
  concurrent checks on the ports of periph_exec.
  assumes: bound into periph_exec; one pclk domain, async reset.
*/
`include "periph_exec_regs.vh"
module periph_exec_properties (
  // apb side
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  // pins and levels
  input wire [5:0]  d_out,
  input wire        c_out,
  input wire        power_flag,
  input wire [7:0]  comparator_value,
  input wire        skip,
  input wire        conv_mode_bit,
  // events
  input wire        conv_start,
  input wire        backup_with_detector,
  input wire        backup_all_stopped,
  input wire        watchdog_stop
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==============================
  // helper logic
  logic [9:0] last_q;
  wire  [9:0] op = pwdata[9:0];
  wire        iw = psel && penable && pwrite && paddr == `OFS_INSTR;
  // a word after the d test opener is its operand, not an op
  wire        x = iw && last_q != `OP_D_TEST;
  wire        armed = last_q == `OP_PD_ARM;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      last_q <= 10'h000;
    else if (iw)
      last_q <= op;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==============================
  // assertions
  a_c_set_drive: assert property (x && op == `OP_C_SET |=> c_out)
    else $error("port c not set");
  a_c_clr_drive: assert property (x && op == `OP_C_CLR |=> !c_out)
    else $error("port c not cleared");
  a_d_all_set: assert property (
    x && op == `OP_D_ALL |=> d_out == 6'h3F)
    else $error("port d not all set");
  a_start_pulse: assert property (
    x && op == `OP_CSTART |=> conv_start ##1 !conv_start)
    else $error("start pulse wrong");
  a_pd_unarmed: assert property (
    x && (op == `OP_PD1 || op == `OP_PD2) && !armed
    |=> !backup_with_detector && !backup_all_stopped)
    else $error("unarmed power-down acted");
  a_pd_first: assert property (
    x && op == `OP_PD1 && armed
    |=> backup_with_detector && !backup_all_stopped)
    else $error("first power-down wrong");
  a_pd_second: assert property (
    x && op == `OP_PD2 && armed
    |=> backup_all_stopped && !backup_with_detector)
    else $error("second power-down wrong");
  a_wd_stop_arm: assert property (
    x && op == `OP_WD_TEST && last_q == `OP_WD_ARM |=> watchdog_stop)
    else $error("watchdog not stopped");
  a_pflag_skip: assert property (
    x && op == `OP_PF_TEST |=> skip == $past(power_flag))
    else $error("power flag skip wrong");
  a_cmp_hold: assert property (
    x && op == `OP_CMP_LD && !conv_mode_bit |=> $stable(comparator_value))
    else $error("comparator changed");
  // ==============================
  // covers
  c_pd_armed: cover property (x && op == `OP_PD1 && armed);
  c_skip_set: cover property ($rose(skip));
  c_wd_stop: cover property (watchdog_stop);
endmodule // periph_exec_properties

bind periph_exec periph_exec_properties i_periph_exec_properties (.*);

// *** tb/periph_exec_tb.sv ***
/*
  self-checking bench of periph_exec: reset and refusal cases,
  then instruction rows, then sequence cases by hand.
  assumes: pins reach the core within 4 pclk.
*/
`include "periph_exec_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module periph_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==============================
  // signals
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  p0_in, p0_out, p0_oe_n, p1_in, p1_out, p1_oe_n;
  logic [1:0]  p2_in, p2_out, p2_oe_n, p3_in, p3_out, p3_oe_n;
  logic [5:0]  d_in, d_out, d_oe_n;
  logic        c_in, c_out, c_oe_n, k_in, k_out, k_oe_n, err;
  logic        power_flag, wdf_set, conv_done_set, skip, conv_start;
  logic        conv_mode_bit, backup_with_detector, backup_all_stopped;
  logic        watchdog_stop, clk_src_rc, onchip_osc_off;
  logic [9:0]  conv_result;
  logic [3:0]  key_wake_ctl_0, key_wake_ctl_1, key_wake_ctl_2;
  logic [3:0]  pullup_ctl_0, pullup_ctl_1, pullup_ctl_2;
  logic [3:0]  conv_ctl_reg, clock_ctl_reg;
  logic [7:0]  comparator_value;
  int          failures, n_checks;
  wire [1:0]   pd = {backup_with_detector, backup_all_stopped};
  localparam logic [9:0] nop = 10'h000;
  // ==============================
  // table: acc, op, acc, op, selector (0 acc, 1 b, 2.. ov), expect
  typedef struct packed {
    logic [3:0] a;
    logic [9:0] op;
    logic [3:0] a2;
    logic [9:0] op2;
    logic [4:0] src;
    logic [7:0] exp;
  } row_t;
  row_t rows [0:30] = '{
    '{4'h0, `OP_IN_P0, 4'h0, nop, 5'h00, 8'h0A},
    '{4'h0, `OP_IN_P1, 4'h0, nop, 5'h00, 8'h05},
    '{4'hF, `OP_IN_P2, 4'h0, nop, 5'h00, 8'h02},
    '{4'hF, `OP_IN_P3, 4'h0, nop, 5'h00, 8'h01},
    '{4'hF, `OP_K_RD, 4'h0, nop, 5'h00, 8'h01},
    '{4'h6, `OP_OUT_P0, 4'h0, nop, 5'h02, 8'h06},
    '{4'h9, `OP_OUT_P1, 4'h0, nop, 5'h03, 8'h09},
    '{4'hE, `OP_OUT_P2, 4'h0, nop, 5'h04, 8'h0E},
    '{4'h5, `OP_OUT_P3, 4'h0, nop, 5'h04, 8'h06},
    '{4'h0, `OP_D_CLR, 4'h0, nop, 5'h05, 8'h3B},
    '{4'h0, `OP_D_CLR, 4'h0, `OP_D_ALL, 5'h05, 8'h3F},
    '{4'h0, `OP_C_CLR, 4'h0, nop, 5'h06, 8'h02},
    '{4'h0, `OP_K_WR, 4'h0, `OP_C_SET, 5'h06, 8'h01},
    '{4'h9, `OP_KW0_LD, 4'h0, `OP_KW0_RD, 5'h00, 8'h09},
    '{4'h3, `OP_KW1_LD, 4'h0, `OP_KW1_RD, 5'h00, 8'h03},
    '{4'hC, `OP_KW2_LD, 4'h0, `OP_KW2_RD, 5'h00, 8'h0C},
    '{4'h5, `OP_PU0_LD, 4'h0, nop, 5'h07, 8'h05},
    '{4'hA, `OP_PU1_LD, 4'h0, nop, 5'h08, 8'h0A},
    '{4'h7, `OP_PU2_LD, 4'h0, nop, 5'h09, 8'h07},
    '{4'h0, `OP_C_TEST, 4'h0, nop, 5'h0B, 8'h01},
    '{4'h3, `OP_CCTL_LD, 4'h0, `OP_CCTL_RD, 5'h00, 8'h03},
    '{4'h0, `OP_RES_RD, 4'h0, nop, 5'h00, 8'h05},
    '{4'h0, `OP_RES_RD, 4'h0, nop, 5'h01, 8'h0B},
    '{4'hF, `OP_LOW_RD, 4'h0, nop, 5'h00, 8'h08},
    '{4'h7, `OP_CMP_LD, 4'h0, nop, 5'h0A, 8'h00},
    '{4'h8, `OP_CCTL_LD, 4'h4, `OP_CMP_LD, 5'h0A, 8'hB4},
    '{4'h0, `OP_RES_RD, 4'h0, nop, 5'h00, 8'h04},
    '{4'h6, `OP_MR_LD, 4'h0, `OP_MR_RD, 5'h00, 8'h06},
    '{4'h0, `OP_PF_TEST, 4'h0, nop, 5'h0B, 8'h01},
    '{4'h0, `OP_RC, 4'h0, nop, 5'h0C, 8'h03},
    '{4'h0, `OP_CERAMIC, 4'h0, nop, 5'h0C, 8'h02}};
  wire [87:0] ov = {6'h0, onchip_osc_off, clk_src_rc, 7'h0, skip,
    comparator_value, 4'h0, pullup_ctl_2, 4'h0, pullup_ctl_1,
    4'h0, pullup_ctl_0, 6'h0, k_out, c_out, 2'h0, d_out,
    4'h0, p3_out, p2_out, 4'h0, p1_out, 4'h0, p0_out};
  // ==============================
  // design and pins
  periph_exec i_periph_exec (.*);
  // open drain: a 0 latch pulls its pin low, else p0..p3 read fixed levels and d, c, k float high
  assign p0_in = 4'hA & p0_oe_n;
  assign p1_in = 4'h5 & p1_oe_n;
  assign p2_in = 2'h2 & p2_oe_n;
  assign p3_in = 2'h1 & p3_oe_n;
  assign d_in = d_oe_n;
  assign c_in = c_oe_n;
  assign k_in = k_oe_n;
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==============================
  // tasks
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 16)
    begin
      failures++;
      complete_run();
    end
    #1;
  endtask
  task automatic wr(input logic [7:0] a, logic [3:0] d);
    apb(1'b1, a, {28'h0, d});
  endtask
  task automatic ex(input logic [9:0] op);
    apb(1'b1, `OFS_INSTR, {22'h0, op});
  endtask
  // one-cycle flag set pulse: 0 watchdog, 1 conversion done
  task automatic kick(input logic sel);
    @(posedge pclk);
    wdf_set <= ~sel;
    conv_done_set <= sel;
    @(posedge pclk);
    wdf_set <= 1'b0;
    conv_done_set <= 1'b0;
  endtask
  // ==============================
  // main sequence
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    power_flag = 1'b1;
    {wdf_set, conv_done_set} = 2'h0;
    conv_result = 10'h2D6;
    failures = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK({p0_out, d_out, skip, conv_ctl_reg}, {4'hF, 6'h3F, 1'b0, 4'h0})
    apb(1'b0, 8'h40, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    wr(`OFS_YREG, 4'h2);
    foreach (rows[i])
    begin
      wr(`OFS_ACC, rows[i].a);
      ex(rows[i].op);
      if (rows[i].op2 != nop)
      begin
        wr(`OFS_ACC, rows[i].a2);
        ex(rows[i].op2);
      end
      if (rows[i].src < 5'h02)
      begin
        apb(1'b0, rows[i].src[0] ? `OFS_BREG : `OFS_ACC, 32'h0);
        `CHK(rd[7:0], rows[i].exp)
      end
      else
        `CHK(ov[int'(rows[i].src) * 8 - 16 +: 8], rows[i].exp)
    end
    // top index of port d, then the two-word test
    wr(`OFS_YREG, 4'h5);
    ex(`OP_D_CLR);
    `CHK(d_out, 6'h1F)
    repeat (6) @(posedge pclk);
    ex(`OP_D_TEST);
    ex(nop);
    `CHK(skip, 1'b0)
    ex(`OP_D_TEST);
    ex(`OP_D_TEST2);
    `CHK(skip, 1'b1)
    ex(`OP_D_SET);
    `CHK(d_out, 6'h3F)
    repeat (6) @(posedge pclk);
    ex(`OP_D_TEST);
    ex(`OP_D_TEST2);
    `CHK(skip, 1'b0)
    // power-down arming
    ex(`OP_PD1);
    `CHK(pd, 2'b00)
    ex(`OP_PD_ARM);
    ex(`OP_PD1);
    `CHK(pd, 2'b10)
    ex(`OP_PD_ARM);
    ex(nop);
    ex(`OP_PD2);
    `CHK(pd, 2'b00)
    ex(`OP_PD_ARM);
    ex(`OP_PD2);
    `CHK(pd, 2'b01)
    // watchdog flag and stop
    kick(1'b0);
    ex(`OP_WD_TEST);
    `CHK(skip, 1'b1)
    ex(`OP_WD_TEST);
    `CHK({skip, watchdog_stop}, 2'b00)
    ex(`OP_WD_ARM);
    ex(`OP_WD_TEST);
    `CHK(watchdog_stop, 1'b1)
    // conversion done flag
    kick(1'b1);
    ex(`OP_DONE_T);
    `CHK(skip, 1'b1)
    ex(`OP_DONE_T);
    `CHK(skip, 1'b0)
    kick(1'b1);
    ex(`OP_CSTART);
    `CHK(conv_start, 1'b1)
    ex(`OP_DONE_T);
    `CHK(skip, 1'b0)
    kick(1'b1);
    wr(`OFS_IRQCTL2, 4'h4);
    ex(`OP_DONE_T);
    `CHK(skip, 1'b0)
    wr(`OFS_IRQCTL2, 4'h0);
    ex(`OP_DONE_T);
    `CHK(skip, 1'b1)
    @(posedge pclk);
    power_flag <= 1'b0;
    ex(`OP_PF_TEST);
    `CHK(skip, 1'b0)
    complete_run();
  end
endmodule // periph_exec_tb
